// ---- rtl/sspi_pkg.sv ----
`default_nettype none
package sspi_pkg;
   // frame geometry
   localparam int unsigned CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] FRAME_LAST = 5'h0F;
   localparam logic [CNT_W-1:0] FRAME_FULL = 5'h10;
   localparam logic [3:0] BIT_TOP = 4'hF;
   // command word layout
   localparam int unsigned OP_MSB = 15;
   localparam int unsigned OP_LSB = 14;
   localparam int unsigned ADDR_MSB = 13;
   localparam int unsigned ADDR_LSB = 8;
   localparam int unsigned DATA_MSB = 7;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ = 2'h0;
   // register space
   localparam int unsigned NREG = 32;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned ADDR_W = 6;
   localparam logic [IDX_W-1:0] IDX_ENDUR = 5'h00;
   localparam logic [IDX_W-1:0] IDX_MEAS_FIRST = 5'h01;
   localparam logic [IDX_W-1:0] IDX_MEAS_LAST = 5'h0B;
   localparam logic [IDX_W-1:0] IDX_AUX = 5'h0B;
   localparam logic [IDX_W-1:0] IDX_CTRL_FIRST = 5'h0C;
   localparam logic [ADDR_W-1:0] CMD_BYTE_ADDR = 6'h3E;
   localparam int unsigned FLASH_BIT = 3;
   localparam int unsigned NEW_DATA_FLAG_BIT = 15;
   localparam int unsigned MEAS_W = 15;
   localparam int unsigned AUX_W = 12;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] ENDUR_STEP = 16'h0001;
   // controller states, one-hot
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN = 2'b10
   } sspi_state_t;
endpackage : sspi_pkg
`default_nettype wire

// ---- rtl/sspi_port.sv ----
`default_nettype none
module sspi_port (
   input wire logic ref_clk, // core clock
   input wire logic rst, // core reset, async, active high
   input wire logic por, // power-on reset of the nonvolatile store
   input wire logic sclk, // serial clock from the master
   input wire logic cs_n, // chip select, active low
   input wire logic mosi, // serial data into the port
   output logic miso_o, // serial data out of the port
   output logic miso_oe, // output enable of serial data
   input wire logic meas_wr, // one-cycle strobe of a new measurement
   input wire logic [sspi_pkg::IDX_W-1:0] meas_idx, // register index of the measurement
   input wire logic [sspi_pkg::MEAS_W-1:0] meas_val, // alarm bit and data bits
   input wire logic [sspi_pkg::IDX_W-1:0] cfg_idx, // working register to show
   output logic [15:0] cfg_data, // working register contents
   output logic flash_done // one-cycle pulse after a flash update
);
   import sspi_pkg::*;

   // ---------------- link side, on the serial clock ----------------

   logic frm_clr; // clears per-frame state outside a frame
   logic [CNT_W-1:0] rx_cnt_q; // rising edges seen in this frame
   logic [15:0] rx_q; // input shifter
   logic [15:0] cmd_hold_q; // last complete command
   logic frm_tgl_q; // toggles once per complete frame
   logic [3:0] tx_idx_q; // output bit position, 0 is the msb
   logic [15:0] tx_word_q; // answer word, owned by the core side
   logic [3:0] tx_sel; // bit picked for the output

   // select high or core reset wipes the frame state
   assign frm_clr = rst | cs_n;

   // sample on rising edges, msb first, stop after sixteen
   always_ff @(posedge sclk or posedge frm_clr) begin
      if (frm_clr) begin
         rx_cnt_q <= CNT_ZERO;
         rx_q <= WORD_RST;
      end else if (rx_cnt_q != FRAME_FULL) begin
         rx_q <= {rx_q[14:0], mosi};
         rx_cnt_q <= rx_cnt_q + CNT_ONE;
      end
   end

   // commit only on the sixteenth rising edge
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         cmd_hold_q <= WORD_RST;
         frm_tgl_q <= 1'b0;
      end else if (!cs_n && rx_cnt_q == FRAME_LAST) begin
         cmd_hold_q <= {rx_q[14:0], mosi};
         frm_tgl_q <= ~frm_tgl_q;
      end
   end

   // advance the output on falling edges, but not the first one
   always_ff @(negedge sclk or posedge frm_clr) begin
      if (frm_clr) begin
         tx_idx_q <= 4'h0;
      end else if (rx_cnt_q != CNT_ZERO && tx_idx_q != BIT_TOP) begin
         tx_idx_q <= tx_idx_q + 4'h1;
      end
   end

   // msb shows as soon as select falls, since the index rests at zero
   assign tx_sel = BIT_TOP - tx_idx_q;
   assign miso_o = tx_word_q[tx_sel];
   assign miso_oe = ~cs_n;

   // ---------------- core side, on the reference clock ----------------

   logic tgl_s1_q; // first synchroniser stage
   logic tgl_s2_q; // second synchroniser stage
   logic tgl_s3_q; // last handled toggle level
   logic frm_ev; // one complete frame waits
   sspi_state_t state_q; // controller state
   sspi_state_t state_d;
   logic [NREG-1:0][15:0] work_q; // working copies
   logic [NREG-1:0][15:0] work_d;
   logic [NREG-1:0][15:0] nv_q; // nonvolatile copies
   logic [NREG-1:0][15:0] nv_d;
   logic [NREG-1:0] new_data_flag_q; // new data flags
   logic [NREG-1:0] new_data_flag_d;
   logic [15:0] tx_word_d;
   logic flash_done_d;
   logic [1:0] cmd_op; // command kind
   logic [ADDR_W-1:0] cmd_addr; // byte address
   logic [IDX_W-1:0] cmd_idx; // register index
   logic [7:0] cmd_data; // write byte
   logic run_ev; // frame taken this cycle
   logic wr_fire; // write command taken
   logic rd_fire; // read command taken
   logic flash_fire; // flash update command taken
   logic ctrl_wr; // write to a working control register
   logic meas_ok; // measurement strobe aimed at an output register
   logic [15:0] rd_val; // word returned for a read

   // index lies in the measurement output block
   function automatic logic is_meas(input logic [IDX_W-1:0] idx);
      is_meas = (idx >= IDX_MEAS_FIRST) && (idx <= IDX_MEAS_LAST);
   endfunction

   // word as the master sees it, flag on top for output registers
   function automatic logic [15:0] rd_word(input logic [IDX_W-1:0] idx,
                                           input logic [15:0] w,
                                           input logic flag);
      rd_word = is_meas(idx) ? {flag, w[14:0]} : w;
   endfunction

   // frame toggle crossing, two flops then the edge stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= frm_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= (state_q == ST_RUN) ? tgl_s2_q : tgl_s3_q;
      end
   end

   // command fields; cmd_hold_q is still for a whole frame after the toggle
   assign frm_ev = tgl_s2_q ^ tgl_s3_q;
   assign run_ev = frm_ev && (state_q == ST_RUN);
   assign cmd_op = cmd_hold_q[OP_MSB:OP_LSB];
   assign cmd_addr = cmd_hold_q[ADDR_MSB:ADDR_LSB];
   assign cmd_idx = cmd_addr[ADDR_W-1:1];
   assign cmd_data = cmd_hold_q[DATA_MSB:0];
   assign wr_fire = run_ev && (cmd_op == OP_WRITE);
   assign rd_fire = run_ev && (cmd_op == OP_READ);
   assign flash_fire = wr_fire && (cmd_addr == CMD_BYTE_ADDR) && cmd_data[FLASH_BIT];
   assign ctrl_wr = wr_fire && (cmd_idx >= IDX_CTRL_FIRST) && (cmd_addr != CMD_BYTE_ADDR);
   assign meas_ok = meas_wr && is_meas(meas_idx);
   // both byte addresses give the same word; data byte is not looked at
   assign rd_val = rd_word(cmd_idx, work_q[cmd_idx],
                           new_data_flag_q[cmd_idx]);

   // load after reset, then serve frames
   always_comb begin
      case (state_q)
         ST_LOAD: state_d = ST_RUN;
         ST_RUN: state_d = ST_RUN;
         default: state_d = ST_LOAD;
      endcase
   end

   // next working, nonvolatile and flag values
   always_comb begin
      work_d = work_q;
      nv_d = nv_q;
      new_data_flag_d = new_data_flag_q;
      flash_done_d = 1'b0;
      tx_word_d = tx_word_q;
      if (state_q == ST_LOAD) begin
         work_d = nv_q;
      end else begin
         // write one byte, upper byte at the odd address
         if (ctrl_wr) begin
            work_d[cmd_idx][cmd_addr[0]*8 +: 8] = cmd_data;
         end
         // persist working settings, count the update
         if (flash_fire) begin
            nv_d = work_q;
            nv_d[IDX_ENDUR] = nv_q[IDX_ENDUR] + ENDUR_STEP;
            work_d[IDX_ENDUR] = nv_q[IDX_ENDUR] + ENDUR_STEP;
            flash_done_d = 1'b1;
         end
         // answer for the next frame; writes answer zero
         if (rd_fire) begin
            tx_word_d = rd_val;
            new_data_flag_d[cmd_idx] = 1'b0;
         end else if (run_ev) begin
            tx_word_d = WORD_RST;
         end
      end
      // measurement update, aux result kept twelve bits unsigned
      if (meas_ok) begin
         work_d[meas_idx] = {1'b0, meas_val};
         if (meas_idx == IDX_AUX) begin
            work_d[meas_idx] = {{(16 - AUX_W){1'b0}}, meas_val[AUX_W-1:0]};
         end
         new_data_flag_d[meas_idx] = 1'b1;
      end
   end

   // controller and working registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_LOAD;
         work_q <= '0;
         new_data_flag_q <= '0;
         tx_word_q <= WORD_RST;
         flash_done <= 1'b0;
      end else begin
         state_q <= state_d;
         work_q <= work_d;
         new_data_flag_q <= new_data_flag_d;
         tx_word_q <= tx_word_d;
         flash_done <= flash_done_d;
      end
   end

   // nonvolatile store survives the core reset
   always_ff @(posedge ref_clk or posedge por) begin
      if (por) begin
         nv_q <= '0;
      end else begin
         nv_q <= nv_d;
      end
   end

   // working copy viewer for the rest of the device
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_data <= WORD_RST;
      end else begin
         cfg_data <= work_q[cfg_idx];
      end
   end

   // ---------------- checks ----------------

   // output disabled whenever select is high
   a_idle_tri_state: assert property (
      @(posedge ref_clk) disable iff (rst) cs_n |-> !miso_oe)
      else $error("serial output enabled while deselected");

   // no commit toggle before the sixteenth edge
   a_short_no_commit: assert property (
      @(posedge sclk) disable iff (rst || cs_n)
      (rx_cnt_q != FRAME_LAST) |=> $stable(frm_tgl_q))
      else $error("frame committed before sixteen edges");

   // first bit in lands in the shifter lsb
   a_rx_msb_first: assert property (
      @(posedge sclk) disable iff (rst || cs_n)
      (rx_cnt_q == CNT_ONE) |-> (rx_q[0] == $past(mosi)))
      else $error("input bit order wrong");

   // msb still on the line at the first rising edge
   a_tx_msb_start: assert property (
      @(posedge sclk) disable iff (rst || cs_n)
      (rx_cnt_q == CNT_ZERO) |-> (miso_o == tx_word_q[15]))
      else $error("msb not presented at frame start");

   // read answer is the full word for the next frame
   a_read_answer: assert property (
      @(posedge ref_clk) disable iff (rst)
      rd_fire |=> (tx_word_q == $past(rd_val)))
      else $error("read answer not loaded");

   // read frame leaves working copies alone
   a_read_no_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      (rd_fire && !meas_wr) |=> $stable(work_q))
      else $error("read frame changed a register");

   // writes other than a flash update never touch the nonvolatile copy
   a_write_volatile: assert property (
      @(posedge ref_clk) disable iff (rst || por)
      (wr_fire && !flash_fire) |=> $stable(nv_q))
      else $error("write reached nonvolatile store");

   // written byte shows in the working word
   a_write_byte: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctrl_wr && !meas_wr) |=>
      (work_q[$past(cmd_idx)][$past(cmd_addr[0])*8 +: 8] == $past(cmd_data)))
      else $error("written byte not stored");

   // reset recovery copies the store into working registers
   a_reset_reload: assert property (
      @(posedge ref_clk) disable iff (rst || por)
      (state_q == ST_LOAD && !meas_wr) |=> (work_q == $past(nv_q)))
      else $error("working copy not reloaded");

   // read clears the flag unless a new sample arrives at once
   a_flag_cleared: assert property (
      @(posedge ref_clk) disable iff (rst)
      (rd_fire && is_meas(cmd_idx) && !meas_wr) |=> !new_data_flag_q[$past(cmd_idx)])
      else $error("new data flag not cleared by read");

   // aux result never exceeds twelve bits
   a_aux_width: assert property (
      @(posedge ref_clk) disable iff (rst)
      work_q[IDX_AUX][15:AUX_W] == 4'h0)
      else $error("aux result wider than twelve bits");

   // flash update bumps the counter in the store
   a_flash_count: assert property (
      @(posedge ref_clk) disable iff (rst || por)
      flash_fire |=> (nv_q[IDX_ENDUR] == $past(nv_q[IDX_ENDUR]) + ENDUR_STEP))
      else $error("flash update count not advanced");

   // flash update leaves a pulse on the next cycle
   a_flash_pulse: assert property (
      @(posedge ref_clk) disable iff (rst)
      flash_fire |=> flash_done)
      else $error("flash completion pulse missing");

   // flash update copies the first control register into the store
   a_flash_copy: assert property (
      @(posedge ref_clk) disable iff (rst || por)
      flash_fire |=> (nv_q[IDX_CTRL_FIRST] == $past(work_q[IDX_CTRL_FIRST])))
      else $error("working copy not stored by flash update");

   // measurement strobe raises the new data flag
   a_meas_flag_set: assert property (
      @(posedge ref_clk) disable iff (rst)
      meas_ok |=> new_data_flag_q[$past(meas_idx)])
      else $error("new data flag not set by a measurement");

   // measurement strobe lands whatever the master does
   a_meas_stored: assert property (
      @(posedge ref_clk) disable iff (rst)
      (meas_ok && meas_idx != IDX_AUX) |=> (work_q[$past(meas_idx)][14:0] == $past(meas_val)))
      else $error("measurement not stored");

   // refused opcodes answer zero in the next frame
   a_refused_op: assert property (
      @(posedge ref_clk) disable iff (rst)
      (run_ev && cmd_op[0]) |=> (tx_word_q == WORD_RST))
      else $error("refused command gave a nonzero answer");

   // writes aimed below the control block are dropped
   a_write_ro: assert property (
      @(posedge ref_clk) disable iff (rst)
      (wr_fire && cmd_idx < IDX_CTRL_FIRST && !meas_wr) |=> $stable(work_q))
      else $error("write reached a read-only register");

   // one output step per falling edge after the first
   a_tx_step: assert property (
      @(posedge sclk) disable iff (rst || cs_n)
      (rx_cnt_q == CNT_ONE) |-> (tx_idx_q == 4'h1))
      else $error("output bit not advanced on the falling edge");

   // main scenarios
   c_read_frame: cover property (@(posedge ref_clk) disable iff (rst) rd_fire);
   c_write_frame: cover property (@(posedge ref_clk) disable iff (rst) ctrl_wr);
   c_flash_update: cover property (@(posedge ref_clk) disable iff (rst) flash_fire);
   c_read_and_sample: cover property (
      @(posedge ref_clk) disable iff (rst) rd_fire && meas_ok && (meas_idx == cmd_idx));

endmodule // sspi_port
`default_nettype wire

// ---- tb/sspi_master.sv ----
`default_nettype none
// behavioural serial master: mode 1/1, sixteen clocks, most significant bit first
module sspi_master (
   output logic sclk, // serial clock, idles high
   output logic cs_n, // chip select, active low
   output logic mosi, // serial data to the port
   input wire logic miso, // resolved serial data from the port
   output logic [15:0] rx_word, // word shifted in by the last full frame
   output logic rx_done // short pulse after each full frame
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam time HALF = 24ns; // half of the 48 ns link period

   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
      rx_word = 16'h0000;
      rx_done = 1'b0;
   end

   // one frame of nbits clocks; fewer than sixteen makes a deliberately short frame
   task automatic frame(input logic [15:0] cmd, input int nbits);
      logic [15:0] rx;
      rx = 16'h0000;
      cs_n = 1'b0; // port puts its top bit out here
      mosi = cmd[15];
      #HALF;
      for (int k = 0; k < nbits; k++) begin
         sclk = 1'b0; // data changes on the falling edge
         mosi = cmd[15-k]; // top bit first
         #HALF;
         sclk = 1'b1; // both ends sample on the rising edge
         rx[15-k] = miso; // answer to the previous command
         #HALF;
      end
      cs_n = 1'b1;
      mosi = ~mosi; // released line never keeps its last value
      if (nbits == 16) begin
         rx_word = rx;
         rx_done = 1'b1;
         #HALF;
         rx_done = 1'b0;
      end
   endtask

   // clock activity while deselected, which the port must ignore
   task automatic idle_toggle(input int n);
      for (int k = 0; k < n; k++) begin
         sclk = 1'b0;
         mosi = k[0];
         #HALF;
         sclk = 1'b1;
         #HALF;
      end
   endtask
endmodule // sspi_master
`default_nettype wire

// ---- tb/sensor_spi_register_port_tb.sv ----
`default_nettype none
module sensor_spi_register_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sspi_pkg::*;
   logic ref_clk, rst, por, meas_wr; // core side inputs
   logic [IDX_W-1:0] meas_idx, cfg_idx; // measurement and view index
   logic [MEAS_W-1:0] meas_val; // measurement value
   logic miso_o, miso_oe, flash_done, sclk, cs_n, mosi, rx_done; // link and status
   logic [15:0] cfg_data, rx_word, nxt; // nxt: answer due in the next frame
   logic [15:0] mem [0:31]; // working copy model
   logic [15:0] nv [0:31]; // nonvolatile copy model
   logic [15:0] exp_q [$]; // expected answer words, oldest first
   wire miso_line = miso_oe ? miso_o : ~miso_o; // released line shows the inverse, no stale value
   int n_fail = 0;
   int checked = 0;

   sspi_port i_dut (.ref_clk(ref_clk), .rst(rst), .por(por), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .meas_wr(meas_wr),
      .meas_idx(meas_idx), .meas_val(meas_val), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
      .flash_done(flash_done));
   sspi_master i_mst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_line),
      .rx_word(rx_word), .rx_done(rx_done));

   // 10 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
      checked++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one full frame: note its expected answer, then update the model
   task automatic xfer(input logic [15:0] cmd);
      logic [IDX_W-1:0] ix;
      ix = cmd[13:9];
      exp_q.push_back(nxt);
      i_mst.frame(cmd, 16);
      nxt = 16'h0000; // writes and bad opcodes answer zero
      if (cmd[15:14] === OP_READ) begin
         nxt = mem[ix]; // whole word for either byte address
         if (ix >= IDX_MEAS_FIRST && ix <= IDX_MEAS_LAST) begin
            mem[ix][NEW_DATA_FLAG_BIT] = 1'b0; // reading clears the flag
         end
      end else if (cmd[15:14] === OP_WRITE && ix >= IDX_CTRL_FIRST
                   && cmd[13:8] !== CMD_BYTE_ADDR) begin
         if (cmd[8]) begin
            mem[ix][15:8] = cmd[7:0];
         end else begin
            mem[ix][7:0] = cmd[7:0];
         end
      end
      repeat (15) @(posedge ref_clk); // gap lets the answer load
      #1;
   endtask

   // view a working register on the side port
   task automatic show(input logic [IDX_W-1:0] ix, input logic [15:0] want);
      cfg_idx = ix;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(cfg_data, want, "working copy");
   endtask

   // watcher: each full frame's answer is checked against the oldest note
   initial forever begin
      @(posedge rx_done);
      if (exp_q.size() == 0) begin
         chk(16'h0000, 16'h0001, "frame without note");
      end else begin
         chk(rx_word, exp_q.pop_front(), "answer word");
      end
   end

   initial begin
      logic [15:0] w;
      rst = 1'b1;
      por = 1'b1;
      meas_wr = 1'b0;
      meas_idx = IDX_MEAS_FIRST;
      meas_val = 15'h0000;
      cfg_idx = IDX_CTRL_FIRST;
      nxt = 16'h0000;
      foreach (mem[i]) begin
         mem[i] = 16'h0000;
         nv[i] = 16'h0000;
      end
      w = $urandom(32'hE1E9B290);
      repeat (6) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      por = 1'b0;
      // two byte writes, then reads by either address, the first with junk in the low byte
      w = 16'($urandom);
      xfer({OP_WRITE, 6'h18, w[7:0]});
      xfer({OP_WRITE, 6'h19, w[15:8]});
      xfer({OP_READ, 6'h19, 8'hA5});
      xfer({OP_READ, 6'h18, 8'h00});
      xfer({2'b01, 6'h18, 8'h55}); // refused opcodes
      xfer({2'b11, 6'h19, 8'h3C});
      xfer({OP_WRITE, 6'h02, 8'hFF}); // output registers refuse writes
      xfer({OP_READ, 6'h02, 8'h00});
      xfer({OP_READ, 6'h18, 8'h00});
      show(5'h0C, mem[12]);
      $display("test write_read done");
      // measurement strobes, read by both addresses so the flag clears
      for (int i = 1; i < 12; i++) begin
         @(posedge ref_clk);
         #1;
         meas_wr = 1'b1;
         meas_idx = IDX_W'(i);
         meas_val = 15'($urandom);
         @(posedge ref_clk);
         #1;
         meas_wr = 1'b0;
         mem[i] = {1'b1, meas_val};
         if (i == IDX_AUX) begin
            mem[i][14:12] = 3'h0; // aux keeps twelve bits
         end
         xfer({OP_READ, 5'(i), 1'b0, 8'h00});
         xfer({OP_READ, 5'(i), 1'b1, 8'h00});
      end
      $display("test measurements done");
      // deselected clocks and a short frame leave everything as it was
      i_mst.idle_toggle(8);
      chk({15'h0000, miso_oe}, 16'h0000, "output enable while deselected");
      i_mst.frame({OP_WRITE, 6'h18, ~mem[12][7:0]}, 8);
      repeat (15) @(posedge ref_clk);
      #1;
      xfer({OP_READ, 6'h18, 8'h00});
      show(5'h0C, mem[12]);
      $display("test ignored traffic done");
      // flash update, later working change, then reset restores the flashed copy
      w = 16'($urandom);
      xfer({OP_WRITE, 6'h1A, w[7:0]});
      fork
         xfer({OP_WRITE, CMD_BYTE_ADDR, 8'h08});
         begin : wait_flash
            int n;
            for (n = 0; n < 200 && flash_done !== 1'b1; n++) begin
               @(posedge ref_clk);
               #1;
            end
            if (n == 200) begin
               chk(16'h0000, 16'h0001, "no flash completion");
               test_done();
            end
         end
      join
      mem[0] = mem[0] + ENDUR_STEP; // count bumps in both copies
      foreach (mem[i]) begin
         nv[i] = mem[i];
      end
      xfer({OP_WRITE, 6'h1A, ~w[7:0]});
      show(5'h0D, mem[13]);
      rst = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      nxt = 16'h0000;
      for (int i = 0; i < 32; i++) begin
         mem[i] = nv[i];
      end
      show(5'h0D, nv[13]);
      xfer({OP_READ, 6'h1A, 8'h00});
      xfer({OP_READ, 6'h00, 8'h00});
      xfer({OP_READ, 6'h01, 8'h00});
      chk(16'(exp_q.size()), 16'h0000, "answers left unchecked");
      $display("test flash_reset done");
      test_done();
   end
endmodule // sensor_spi_register_port_tb
`default_nettype wire
